/* src/aes_round_pkg.sv */
// package: operation codes, field constants and substitution tables for the round primitives
package aes_round_pkg;

  // state geometry: sixteen bytes, four rows by four columns
  localparam int STATE_BITS = 128;
  localparam int BYTE_BITS = 8;
  localparam int ROWS = 4;
  localparam int COLS = 4;

  // low byte of the reduction polynomial x^8 + x^4 + x^3 + x + 1
  localparam logic [7:0] REDUCE_POLY = 8'h1B;

  // coefficients used by column mixing and its inverse
  localparam logic [7:0] COEF_2 = 8'h02;
  localparam logic [7:0] COEF_3 = 8'h03;
  localparam logic [7:0] COEF_9 = 8'h09;
  localparam logic [7:0] COEF_B = 8'h0B;
  localparam logic [7:0] COEF_D = 8'h0D;
  localparam logic [7:0] COEF_E = 8'h0E;

  // operation select presented by the requester
  typedef enum logic [3:0] {
    op_column_mixing,
    op_inverse_column_mixing,
    op_row_shifting,
    op_inverse_row_shifting,
    op_byte_substitution,
    op_inverse_byte_substitution,
    op_word_substitution,
    op_word_rotation,
    op_field_product,
    op_field_sum
  } aes_op_e;

  // forward table, entry 00 in the top byte, entry FF in the bottom byte
  localparam logic [2047:0] FWD_TABLE = {
    128'h637C777BF26B6FC53001672BFED7AB76, 128'hCA82C97DFA5947F0ADD4A2AF9CA472C0,
    128'hB7FD9326363FF7CC34A5E5F171D83115, 128'h04C723C31896059A071280E2EB27B275,
    128'h09832C1A1B6E5AA0523BD6B329E32F84, 128'h53D100ED20FCB15B6ACBBE394A4C58CF,
    128'hD0EFAAFB434D338545F9027F503C9FA8, 128'h51A3408F929D38F5BCB6DA2110FFF3D2,
    128'hCD0C13EC5F974417C4A77E3D645D1973, 128'h60814FDC222A908846EEB814DE5E0BDB,
    128'hE0323A0A4906245CC2D3AC629195E479, 128'hE7C8376D8DD54EA96C56F4EA657AAE08,
    128'hBA78252E1CA6B4C6E8DD741F4BBD8B8A, 128'h703EB5664803F60E613557B986C11D9E,
    128'hE1F8981169D98E949B1E87E9CE5528DF, 128'h8CA1890DBFE6426841992D0FB054BB16
  };

  // inverse table, same layout
  localparam logic [2047:0] INV_TABLE = {
    128'h52096AD53036A538BF40A39E81F3D7FB, 128'h7CE339829B2FFF87348E4344C4DEE9CB,
    128'h547B9432A6C2233DEE4C950B42FAC34E, 128'h082EA16628D924B2765BA2496D8BD125,
    128'h72F8F66486689816D4A45CCC5D65B692, 128'h6C704850FDEDB9DA5E154657A78D9D84,
    128'h90D8AB008CBCD30AF7E45805B8B34506, 128'hD02C1E8FCA3F0F02C1AFBD0301138A6B,
    128'h3A9111414F67DCEA97F2CFCEF0B4E673, 128'h96AC7422E7AD3585E2F937E81C75DF6E,
    128'h47F11A711D29C5896FB7620EAA18BE1B, 128'hFC563E4BC6D279209ADBC0FE78CD5AF4,
    128'h1FDDA8338807C731B11210592780EC5F, 128'h60517FA919B54A0D2DE57A9F93C99CEF,
    128'hA0E03B4DAE2AF5B0C8EBBB3C83539961, 128'h172B047EBA77D626E169146355210C7D
  };

  // entry n sits at bit 8*(255-n), i.e. {~n, 3'h0}: upper nibble row, lower nibble column
  function automatic logic [7:0] fwd_lookup(input logic [7:0] x);
    return FWD_TABLE[{~x, 3'h0} +: 8];
  endfunction

  function automatic logic [7:0] inv_lookup(input logic [7:0] x);
    return INV_TABLE[{~x, 3'h0} +: 8];
  endfunction

endpackage

/* src/aes_field_mul.sv */
// field product of two bytes in the 256-element field, reduced on the fly
`timescale 1ns/1ps
`default_nettype none

module aes_field_mul (
  // operands
  input wire logic [7:0] mul_a,
  input wire logic [7:0] mul_b,
  // product
  output logic [7:0] mul_p
);

  // shift-and-add with reduction at every step keeps the partial product one byte wide
  always_comb begin
    logic [7:0] acc;
    logic [7:0] shifted;
    acc = 8'h00;
    shifted = mul_a;
    for (int k = 0; k < aes_round_pkg::BYTE_BITS; k++) begin
      if (mul_b[k]) begin // bit k is the coefficient of x^k
        acc = acc ^ shifted; // carry-less addition is exclusive or
      end
      // multiply by x, folding x^8 back through the polynomial
      shifted = {shifted[aes_round_pkg::BYTE_BITS-2:0], 1'h0} ^
                (shifted[aes_round_pkg::BYTE_BITS-1] ? aes_round_pkg::REDUCE_POLY : 8'h00);
    end
    mul_p = acc;
  end

endmodule

`default_nettype wire

/* src/aes_round_primitives.sv */
// round primitive datapath: mixing, shifting, substitution, rotation and field arithmetic
//
// Contract
// - state is sixteen bytes; row i column j is byte 4j+i, row 3 most significant
// - all primitives use little-endian byte numbering of the state
// - column mixing: rows use 2,3,1,1 coefficients rotating per row, every column
// - field addition of two bytes is bitwise exclusive or
// - field product: carry-less multiply then reduce modulo x^8+x^4+x^3+x+1
// - bit k of a byte is the coefficient of x^k
// - word rotation: output bytes 3,2,1,0 take input bytes 0,3,2,1
// - row shifting: row r rotates r places toward lower column index
// - byte substitution: table lookup indexed by upper then lower nibble
// - forward table holds the standard values, 00->63, 01->7C, FF->16
// - word substitution: each byte of a word through forward table, same position
// - inverse column mixing: coefficients 0E,0B,0D,09 rotating right per row
// - inverse row shifting: row r rotates r places toward higher column index
// - inverse substitution table: 00->52, 01->09, FF->7D
`timescale 1ns/1ps
`default_nettype none

module aes_round_primitives (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // request from the execution pipeline
  input wire logic in_valid,
  input wire logic [3:0] in_op,
  input wire logic [127:0] in_state,
  input wire logic [7:0] in_byte_a,
  input wire logic [7:0] in_byte_b,
  // registered answer
  output logic out_valid,
  output logic [127:0] out_result
);

  ////////////////////////////////////////////////////////////////////////////
  // geometry comes from the package so no byte or column count is written inline

  localparam int BW = aes_round_pkg::BYTE_BITS;
  localparam int NBYTES = aes_round_pkg::STATE_BITS / BW;
  localparam int NROWS = aes_round_pkg::ROWS;
  localparam int NCOLS = aes_round_pkg::COLS;
  localparam int WORD_BITS = NROWS * BW;
  localparam int TABLE_DEPTH = 1 << BW;
  localparam int PAD_BITS = aes_round_pkg::STATE_BITS - BW;

  ////////////////////////////////////////////////////////////////////////////
  // byte view of the state and the candidate results

  // request bytes and one product array per mixing coefficient other than 1
  logic [BW-1:0] s [NBYTES];
  logic [BW-1:0] m2 [NBYTES];
  logic [BW-1:0] m3 [NBYTES];
  logic [BW-1:0] m9 [NBYTES];
  logic [BW-1:0] mb [NBYTES];
  logic [BW-1:0] md [NBYTES];
  logic [BW-1:0] me [NBYTES];

  // substitution tables, one byte per entry
  logic [BW-1:0] fwd_rom [TABLE_DEPTH];
  logic [BW-1:0] inv_rom [TABLE_DEPTH];

  // one candidate per primitive, word substitution sharing sub_fwd; full width except the byte-wide product and sum; the select below picks one
  logic [aes_round_pkg::STATE_BITS-1:0] mix_fwd;
  logic [aes_round_pkg::STATE_BITS-1:0] mix_inv;
  logic [aes_round_pkg::STATE_BITS-1:0] shift_fwd;
  logic [aes_round_pkg::STATE_BITS-1:0] shift_inv;
  logic [aes_round_pkg::STATE_BITS-1:0] sub_fwd;
  logic [aes_round_pkg::STATE_BITS-1:0] sub_inv;
  logic [aes_round_pkg::STATE_BITS-1:0] rot_words;
  logic [BW-1:0] product;
  logic [BW-1:0] field_sum;
  logic [aes_round_pkg::STATE_BITS-1:0] result_next;

  // byte n is bits 8n+7..8n, so byte 0 is the low-order byte
  generate
    for (genvar n = 0; n < NBYTES; n++) begin : g_bytes
      assign s[n] = in_state[BW*n +: BW];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // substitution tables

  // unpacked from the packed constants into arrays that the lookups index directly;
  // entry v is row v[7:4], column v[3:0] of the table
  generate
    for (genvar v = 0; v < TABLE_DEPTH; v++) begin : g_rom
      // entry 00 sits in the top byte of each packed constant
      assign fwd_rom[v] = aes_round_pkg::FWD_TABLE[BW*(TABLE_DEPTH-1-v) +: BW];
      assign inv_rom[v] = aes_round_pkg::INV_TABLE[BW*(TABLE_DEPTH-1-v) +: BW];
    end
  endgenerate

  // every byte through both tables; word substitution reuses the forward result
  generate
    for (genvar n = 0; n < NBYTES; n++) begin : g_sub
      assign sub_fwd[BW*n +: BW] = fwd_rom[s[n]];
      assign sub_inv[BW*n +: BW] = inv_rom[s[n]];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // constant multipliers

  // six multipliers per byte; with one operand constant each folds to a few gates,
  // which costs area but keeps both mixing directions to a single level of logic
  generate
    for (genvar n = 0; n < NBYTES; n++) begin : g_mul
      aes_field_mul u_m2 (
        .mul_a(aes_round_pkg::COEF_2),
        .mul_b(s[n]),
        .mul_p(m2[n])
      );
      aes_field_mul u_m3 (
        .mul_a(aes_round_pkg::COEF_3),
        .mul_b(s[n]),
        .mul_p(m3[n])
      );
      aes_field_mul u_m9 (
        .mul_a(aes_round_pkg::COEF_9),
        .mul_b(s[n]),
        .mul_p(m9[n])
      );
      aes_field_mul u_mb (
        .mul_a(aes_round_pkg::COEF_B),
        .mul_b(s[n]),
        .mul_p(mb[n])
      );
      aes_field_mul u_md (
        .mul_a(aes_round_pkg::COEF_D),
        .mul_b(s[n]),
        .mul_p(md[n])
      );
      aes_field_mul u_me (
        .mul_a(aes_round_pkg::COEF_E),
        .mul_b(s[n]),
        .mul_p(me[n])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // column mixing and its inverse

  generate
    for (genvar j = 0; j < NCOLS; j++) begin : g_mix
      for (genvar i = 0; i < NROWS; i++) begin : g_row
        // byte of row i and its three neighbours down the same column, wrapping round
        localparam int B0 = NROWS * j + i;
        localparam int B1 = NROWS * j + (i + 1) % NROWS;
        localparam int B2 = NROWS * j + (i + 2) % NROWS;
        localparam int B3 = NROWS * j + (i + 3) % NROWS;
        // 2*s_i ^ 3*s_i+1 ^ s_i+2 ^ s_i+3, same for all columns
        assign mix_fwd[BW*B0 +: BW] = m2[B0] ^ m3[B1] ^ s[B2] ^ s[B3];
        // 0E,0B,0D,09 sequence rotated right once per row
        assign mix_inv[BW*B0 +: BW] = me[B0] ^ mb[B1] ^ md[B2] ^ m9[B3];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // row and word permutations: pure wiring, no gates

  generate
    for (genvar j = 0; j < NCOLS; j++) begin : g_shift
      for (genvar i = 0; i < NROWS; i++) begin : g_row
        // row i takes column j+i: bytes move toward lower column index
        assign shift_fwd[BW*(NROWS*j+i) +: BW] = s[NROWS*((j+i)%NCOLS)+i];
        // row i takes column j-i: bytes move toward higher column index
        assign shift_inv[BW*(NROWS*j+i) +: BW] = s[NROWS*((j+NCOLS-i)%NCOLS)+i];
      end
    end
  endgenerate

  // column word j keeps row 3 on top; one byte rotate right within each word
  generate
    for (genvar j = 0; j < NCOLS; j++) begin : g_rot
      assign rot_words[WORD_BITS*j +: WORD_BITS] = {
        s[NROWS*j], s[NROWS*j+3], s[NROWS*j+2], s[NROWS*j+1]
      };
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // standalone field arithmetic

  // the standalone product uses the same reducing multiplier as the mixing paths
  aes_field_mul u_product (
    .mul_a(in_byte_a),
    .mul_b(in_byte_b),
    .mul_p(product)
  );

  // field addition needs no multiplier, only exclusive or
  assign field_sum = in_byte_a ^ in_byte_b;

  ////////////////////////////////////////////////////////////////////////////
  // operation select

  // illegal select codes give zero so a stray op cannot leak a stale value
  always_comb begin
    unique case (aes_round_pkg::aes_op_e'(in_op))
      aes_round_pkg::op_column_mixing: result_next = mix_fwd;
      aes_round_pkg::op_inverse_column_mixing: result_next = mix_inv;
      aes_round_pkg::op_row_shifting: result_next = shift_fwd;
      aes_round_pkg::op_inverse_row_shifting: result_next = shift_inv;
      aes_round_pkg::op_byte_substitution: result_next = sub_fwd;
      aes_round_pkg::op_inverse_byte_substitution: result_next = sub_inv;
      aes_round_pkg::op_word_substitution: result_next = sub_fwd; // bytewise, positions kept
      aes_round_pkg::op_word_rotation: result_next = rot_words;
      aes_round_pkg::op_field_product: result_next = {{PAD_BITS{1'h0}}, product};
      aes_round_pkg::op_field_sum: result_next = {{PAD_BITS{1'h0}}, field_sum};
      default: result_next = 128'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered answer

  // valid follows the request by exactly one clock
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      out_valid <= 1'h0;
    end else begin
      out_valid <= in_valid;
    end
  end

  // result holds between requests so a slow consumer can still read it
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      out_result <= 128'h0;
    end else if (in_valid) begin
      out_result <= result_next;
    end
  end

endmodule

`default_nettype wire

/* sim/aes_round_primitives_properties.sv */
// checker: timing and field relations at the round primitive ports
`timescale 1ns/1ps
`default_nettype none
module aes_round_primitives_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // request and answer
  input wire logic in_valid,
  input wire logic [3:0] in_op,
  input wire logic [127:0] in_state,
  input wire logic [7:0] in_byte_a,
  input wire logic [7:0] in_byte_b,
  input wire logic out_valid,
  input wire logic [127:0] out_result
);
  logic [127:0] st_q;
  logic [7:0] sum_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // copies of the request so each result is tied to what was taken
  always_ff @(posedge core_clk) begin
    st_q <= in_state;
    sum_q <= in_byte_a ^ in_byte_b;
  end
  a_valid_follows: assert property (in_valid |=> out_valid) else $error("no answer after request");
  a_idle_quiet: assert property (!in_valid |=> !out_valid) else $error("answer without request");
  a_result_holds: assert property (!in_valid |=> $stable(out_result)) else $error("result moved");
  a_sum_xor: assert property (in_valid && in_op == 4'h9 |=> out_result == {120'h0, sum_q})
    else $error("bad field sum");
  a_word_rotate: assert property (in_valid && in_op == 4'h7 |=> out_result[31:0] == {st_q[7:0], st_q[31:8]})
    else $error("bad word rotation");
  a_row_shift: assert property (in_valid && in_op == 4'h2 |=> out_result[15:0] == {st_q[47:40], st_q[7:0]})
    else $error("bad row shifting");
  a_row_unshift: assert property (in_valid && in_op == 4'h3 |=> out_result[15:0] == {st_q[111:104], st_q[7:0]})
    else $error("bad inverse row shifting");
  a_bad_op_zero: assert property (in_valid && in_op > 4'h9 |=> out_result == 128'h0) else $error("illegal op");
  a_reset_clear: assert property (disable iff (1'b0) !rst_b |=> !out_valid && out_result == 128'h0)
    else $error("reset did not clear");
endmodule
bind aes_round_primitives aes_round_primitives_properties aes_round_primitives_properties_i (
  .core_clk(core_clk), .rst_b(rst_b), .in_valid(in_valid), .in_op(in_op), .in_state(in_state),
  .in_byte_a(in_byte_a), .in_byte_b(in_byte_b), .out_valid(out_valid), .out_result(out_result));
`default_nettype wire

/* sim/op_source.sv */
// partner model: pipeline stage that presents round requests
`timescale 1ns/1ps
`default_nettype none
module op_source (
  // clock
  input wire logic core_clk,
  // request to the datapath
  output logic in_valid,
  output logic [3:0] in_op,
  output logic [127:0] in_state,
  output logic [7:0] in_byte_a,
  output logic [7:0] in_byte_b
);
  // all fields carry a value from time zero
  initial begin
    in_valid = 1'b0;
    in_op = 4'h0;
    in_state = 128'h0;
    {in_byte_a, in_byte_b} = 16'h0;
  end
  // one request: every field changes together just after an edge
  task automatic send(input logic [3:0] op, input logic [127:0] s, input logic [7:0] a, input logic [7:0] b);
    in_valid <= 1'b1;
    in_op <= op;
    in_state <= s;
    {in_byte_a, in_byte_b} <= {a, b};
    @(posedge core_clk);
  endtask
  // idle: fields are no longer qualified, so state and op wander while the byte operands hold
  task automatic idle();
    in_valid <= 1'b0;
    in_state <= ~in_state;
    in_op <= ~in_op;
    @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

/* sim/tb_aes_round_primitives.sv */
// testbench: directed and random round requests with a scoreboard on the answers
`timescale 1ns/1ps
`default_nettype none
module tb_aes_round_primitives;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic in_valid, out_valid;
  logic [3:0] in_op;
  logic [127:0] in_state, out_result, e;
  logic [7:0] in_byte_a, in_byte_b;
  logic [127:0] exp_q [$];
  int error_cnt = 0;
  int total_checks = 0;
  integer seed = 70833;
  always #10 core_clk = ~core_clk;
  op_source op_source_i (.core_clk(core_clk), .in_valid(in_valid), .in_op(in_op), .in_state(in_state),
    .in_byte_a(in_byte_a), .in_byte_b(in_byte_b));
  aes_round_primitives aes_round_primitives_i (.core_clk(core_clk), .rst_b(rst_b), .in_valid(in_valid),
    .in_op(in_op), .in_state(in_state), .in_byte_a(in_byte_a), .in_byte_b(in_byte_b),
    .out_valid(out_valid), .out_result(out_result));
  ////////////////////////////////////////////////////////////////////////////////
  // reference arithmetic, bit k of a byte weighs x^k
  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ a;
      a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
    end
    return p;
  endfunction
  function automatic logic [127:0] calc(input logic [3:0] op, input logic [127:0] s, input logic [7:0] a,
                                        input logic [7:0] b);
    logic [127:0] r;
    logic [7:0] c [4];
    r = 128'h0;
    if (op == 4'h0) c = '{8'h02, 8'h03, 8'h01, 8'h01};
    else c = '{8'h0E, 8'h0B, 8'h0D, 8'h09};
    for (int j = 0; j < 4; j++) begin
      for (int i = 0; i < 4; i++) begin
        case (op)
          4'h0, 4'h1: for (int k = 0; k < 4; k++) r[32*j+8*i+:8] ^= gm(c[(k-i)&3], s[32*j+8*k+:8]);
          4'h2: r[32*j+8*i+:8] = s[32*((j+i)&3)+8*i+:8];
          4'h3: r[32*j+8*i+:8] = s[32*((j-i)&3)+8*i+:8];
          4'h4, 4'h6: r[32*j+8*i+:8] = aes_round_pkg::FWD_TABLE[{~s[32*j+8*i+:8], 3'h0}+:8];
          4'h5: r[32*j+8*i+:8] = aes_round_pkg::INV_TABLE[{~s[32*j+8*i+:8], 3'h0}+:8];
          4'h7: r[32*j+:32] = {s[32*j+:8], s[32*j+8+:24]};
          4'h8: r = {120'h0, gm(a, b)};
          4'h9: r = {120'h0, a ^ b};
          default: r = 128'h0;
        endcase
      end
    end
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // note the expectation, then hand the request to the pipeline model
  task automatic req(input logic [3:0] op, input logic [127:0] s, input logic [7:0] a, input logic [7:0] b,
                     input logic [127:0] x);
    exp_q.push_back(x);
    op_source_i.send(op, s, a, b);
  endtask
  task automatic rq(input logic [3:0] op);
    logic [127:0] s;
    logic [7:0] a, b;
    s = {$random(seed), $random(seed), $random(seed), $random(seed)};
    a = 8'($random(seed));
    b = 8'($random(seed));
    req(op, s, a, b, calc(op, s, a, b));
  endtask
  // scoreboard: every answer must match the oldest note; an answer with no note is a fault
  always @(negedge core_clk) begin
    if (out_valid === 1'b1) begin
      if (exp_q.size() == 0) check({127'h0, out_valid}, 128'h0);
      else check(out_result, exp_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: known vectors back to back, then op codes 0 to 15 in turn with random data and gaps, then a second reset
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    e = calc(4'h0, 128'hE598271EF11141B8AE52B4E0305DBFD4, 8'h00, 8'h00);
    e[31:0] = 32'hE5816604;
    req(4'h0, 128'hE598271EF11141B8AE52B4E0305DBFD4, 8'h00, 8'h00, e);
    req(4'h8, 128'h0, 8'h57, 8'h83, 128'hC1);
    req(4'h4, 128'hFF0100, 8'h00, 8'h00, {{13{8'h63}}, 24'h167C63});
    req(4'h5, 128'hFF0100, 8'h00, 8'h00, {{13{8'h52}}, 24'h7D0952});
    for (int n = 0; n < 48; n++) begin
      if ($random(seed) & 1) op_source_i.idle();
      rq(n[3:0]);
    end
    repeat (2) op_source_i.idle();
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    check(out_result, 128'h0);
    @(posedge core_clk);
    rq(4'h1);
    op_source_i.idle();
    for (int w = 0; w < 10 && exp_q.size() != 0; w++) @(posedge core_clk);
    check(128'(exp_q.size()), 128'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
